/* src/sbarb_pkg.sv */
// Overview of operation
// - Idle bus parks on bridge or last owner
// - Control bit picks bridge tier, default high
// - Control bit picks grant line 0 tier
// - Enabled watch expires after 16 idle clocks
// - Auto-mask bit masks the expired requester
// - Ignore bit drops request line 0
// - Expiry sets sticky per-port flag until cleared
// - Status bits 7:6 always read zero
// - Only fundamental reset restores control and mask
// - Two tiers; bridge alone high at reset
package sbarb_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] ADDR_CTRL = 8'hdc;
    localparam logic [7:0] ADDR_MASK = 8'hdd;
    localparam logic [7:0] ADDR_TSTAT = 8'hde;
    localparam logic [7:0] CTRL_RST = 8'h40;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [5:0] TSTAT_RST = 6'h00;
    // ==========================================================
    // Field positions
    localparam int CTRL_PARK_BIT = 7;
    localparam int CTRL_BRIDGE_TIER_BIT = 6;
    localparam int CTRL_PORT0_TIER_BIT = 0;
    localparam int MASK_WATCH_BIT = 7;
    localparam int MASK_AUTO_BIT = 6;
    localparam int MASK_IGNORE0_BIT = 0;
    // ==========================================================
    // Masters and timing
    localparam int NUM_PORTS = 6;
    localparam logic [2:0] BRIDGE_IDX = 3'h6;
    localparam logic [2:0] LOWER_SLOT = 3'h7;
    localparam int WATCH_CLKS = 16;
endpackage : sbarb_pkg

/* src/sbarb_watch_if.sv */
`timescale 1ns/100ps
interface sbarb_watch_if;
    logic run;
    logic expired;
    modport owner (output run, input expired);
    modport timer (input run, output expired);
endinterface : sbarb_watch_if

/* src/sbarb_watch.sv */
`timescale 1ns/100ps
module sbarb_watch #(
    parameter int unsigned WATCH_CLKS = 16
) (
    input wire logic clk_in,
    input wire logic rst_in,
    sbarb_watch_if.timer watch
);
    import sbarb_pkg::*;

    localparam int CW = $clog2(WATCH_CLKS + 1);
    localparam logic [CW-1:0] LAST = CW'(WATCH_CLKS - 1);

    if (WATCH_CLKS < 2 || WATCH_CLKS > 200) begin : g_bad_len
        $error("sbarb_watch: WATCH_CLKS out of range");
    end

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic expired;
        logic [CW:0] len;
    } sbarb_watch_t;

    sbarb_watch_t q;
    sbarb_watch_t d;

    // ==========================================================
    // Idle-clock counter
    always_comb begin
        d = q;
        d.cnt = (watch.run && q.cnt != LAST) ? CW'(q.cnt + 1'b1) : '0;
        d.expired = watch.run && q.cnt == LAST;
        d.len = !watch.run ? '0 : (q.expired ? (CW+1)'(1) : (CW+1)'(q.len + 1'b1));
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign watch.expired = q.expired;

    // ==========================================================
    // Checks
    property p_expire_len;
        @(posedge clk_in) disable iff (rst_in)
        q.expired |-> q.len == (CW+1)'(WATCH_CLKS);
    endproperty
    a_expire_len: assert property (p_expire_len) else $error("expiry off count");

    property p_no_run_no_expire;
        @(posedge clk_in) disable iff (rst_in)
        !watch.run |=> !q.expired;
    endproperty
    a_no_run_no_expire: assert property (p_no_run_no_expire) else $error("expiry idle");
endmodule : sbarb_watch

/* src/sbarb_arbiter.sv */
`timescale 1ns/100ps
module sbarb_arbiter (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic hot_rst_in,
    input wire logic [sbarb_pkg::NUM_PORTS-1:0] request_line_n_in,
    input wire logic frame_n_in,
    input wire logic irdy_n_in,
    input wire logic bridge_req_in,
    input wire logic [7:0] cfg_addr_in,
    input wire logic cfg_wr_in,
    input wire logic cfg_rd_in,
    input wire logic [7:0] cfg_wdata_in,
    output logic [sbarb_pkg::NUM_PORTS-1:0] grant_line_n_out,
    output logic bridge_gnt_out,
    output logic [7:0] cfg_rdata_out
);
    import sbarb_pkg::*;

    typedef struct packed {
        logic [NUM_PORTS-1:0] req_s1;
        logic [NUM_PORTS-1:0] req_s2;
        logic frame_s1;
        logic frame_s2;
        logic irdy_s1;
        logic irdy_s2;
        logic frame_d;
        logic [7:0] ctrl;
        logic [7:0] mask;
        logic [5:0] tstat;
        logic [5:0] amask;
        logic [2:0] grantee;
        logic [2:0] owner;
        logic [2:0] hi_last;
        logic [2:0] lo_last;
        logic [NUM_PORTS-1:0] gnt_n;
        logic bgnt;
        logic [7:0] rdata;
    } sbarb_state_t;

    localparam sbarb_state_t ST_RST = '{
        req_s1: '1, req_s2: '1, frame_s1: 1'b1, frame_s2: 1'b1,
        irdy_s1: 1'b1, irdy_s2: 1'b1, frame_d: 1'b1,
        ctrl: CTRL_RST, mask: MASK_RST, tstat: TSTAT_RST, amask: '0,
        grantee: BRIDGE_IDX, owner: BRIDGE_IDX, hi_last: '0, lo_last: '0,
        gnt_n: '1, bgnt: 1'b1, rdata: '0};

    sbarb_state_t q;
    sbarb_state_t d;

    logic [6:0] r;
    logic [6:0] hi_mem;
    logic [6:0] r_arb;
    logic [7:0] hv;
    logic [3:0] hpick;
    logic [3:0] lpick;
    logic bus_idle;
    logic arb_go;
    logic clr_hit;

    sbarb_watch_if watch_bus ();

    // ==========================================================
    // Round-robin search starting after the last winner
    function automatic logic [3:0] rr8(input logic [7:0] v, input logic [2:0] last);
        logic f;
        logic [2:0] j;
        logic [2:0] k;
        f = 1'b0;
        k = '0;
        for (int i = 1; i <= 8; i++) begin
            j = 3'(int'(last) + i);
            if (!f && v[j]) begin
                f = 1'b1;
                k = j;
            end
        end
        return {f, k};
    endfunction : rr8

    // ==========================================================
    // Request qualification and tiers
    assign bus_idle = q.frame_s2 && q.irdy_s2;
    assign r[5:1] = ~q.req_s2[5:1] & ~q.amask[5:1];
    assign r[0] = ~q.req_s2[0] & ~q.amask[0] & ~q.mask[MASK_IGNORE0_BIT];
    assign r[6] = bridge_req_in;
    assign hi_mem = {q.ctrl[CTRL_BRIDGE_TIER_BIT], 5'h00, q.ctrl[CTRL_PORT0_TIER_BIT]};
    // Expired grantee sits out the arbitration its expiry triggers
    assign r_arb = r & ~({6'h00, watch_bus.expired} << q.grantee);
    assign hv = {|(r_arb & ~hi_mem), r_arb & hi_mem};
    assign hpick = rr8(hv, q.hi_last);
    assign lpick = rr8({1'b0, r_arb & ~hi_mem}, q.lo_last);
    assign arb_go = bus_idle && (!r[q.grantee] || watch_bus.expired);
    assign clr_hit = cfg_wr_in && cfg_addr_in == ADDR_TSTAT;
    assign watch_bus.run = q.mask[MASK_WATCH_BIT] && bus_idle && q.grantee < BRIDGE_IDX
        && r[q.grantee];

    sbarb_watch #(.WATCH_CLKS(WATCH_CLKS)) u_watch (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .watch(watch_bus)
    );

    // ==========================================================
    // Next state
    always_comb begin
        d = q;
        d.req_s1 = request_line_n_in;
        d.req_s2 = q.req_s1;
        d.frame_s1 = frame_n_in;
        d.frame_s2 = q.frame_s1;
        d.irdy_s1 = irdy_n_in;
        d.irdy_s2 = q.irdy_s1;
        d.frame_d = q.frame_s2;
        if (cfg_wr_in) begin
            case (cfg_addr_in)
                ADDR_CTRL: d.ctrl = cfg_wdata_in;
                ADDR_MASK: d.mask = cfg_wdata_in;
                ADDR_TSTAT: begin
                    d.tstat = q.tstat & ~cfg_wdata_in[5:0];
                    d.amask = q.amask & ~cfg_wdata_in[5:0];
                end
                default: ;
            endcase
        end
        if (watch_bus.expired && q.grantee < BRIDGE_IDX) begin
            d.tstat[q.grantee] = 1'b1;
            if (q.mask[MASK_AUTO_BIT]) begin
                d.amask[q.grantee] = 1'b1;
            end
        end
        if (cfg_rd_in) begin
            case (cfg_addr_in)
                ADDR_CTRL: d.rdata = q.ctrl;
                ADDR_MASK: d.rdata = q.mask;
                ADDR_TSTAT: d.rdata = {2'b00, q.tstat};
                default: d.rdata = '0;
            endcase
        end
        if (hot_rst_in) begin
            d.grantee = BRIDGE_IDX;
            d.owner = BRIDGE_IDX;
            d.hi_last = '0;
            d.lo_last = '0;
        end else begin
            if (!q.frame_s2 && q.frame_d) begin
                d.owner = q.grantee;
            end
            if (arb_go) begin
                if (hpick[3]) begin
                    d.hi_last = hpick[2:0];
                    if (hpick[2:0] == LOWER_SLOT) begin
                        d.grantee = lpick[2:0];
                        d.lo_last = lpick[2:0];
                    end else begin
                        d.grantee = hpick[2:0];
                    end
                end else if (q.ctrl[CTRL_PARK_BIT]) begin
                    d.grantee = BRIDGE_IDX;
                end else begin
                    d.grantee = q.owner;
                end
            end
        end
        for (int i = 0; i < NUM_PORTS; i++) begin
            d.gnt_n[i] = d.grantee != 3'(i);
        end
        d.bgnt = d.grantee == BRIDGE_IDX;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    assign grant_line_n_out = q.gnt_n;
    assign bridge_gnt_out = q.bgnt;
    assign cfg_rdata_out = q.rdata;

    // ==========================================================
    // Checks
    property p_park_bridge;
        @(posedge clk_in) disable iff (rst_in || hot_rst_in)
        (arb_go && r == 7'h00 && q.ctrl[CTRL_PARK_BIT]) |=> q.grantee == BRIDGE_IDX;
    endproperty
    a_park_bridge: assert property (p_park_bridge) else $error("not parked on bridge");

    property p_park_last;
        @(posedge clk_in) disable iff (rst_in || hot_rst_in)
        (arb_go && r == 7'h00 && !q.ctrl[CTRL_PARK_BIT]) |=> q.grantee == $past(q.owner);
    endproperty
    a_park_last: assert property (p_park_last) else $error("not parked on owner");

    property p_bridge_tier;
        @(posedge clk_in) disable iff (rst_in || hot_rst_in)
        (arb_go && q.hi_last == LOWER_SLOT && r[6] && q.ctrl[CTRL_BRIDGE_TIER_BIT])
            |=> q.grantee == BRIDGE_IDX
            || (q.grantee == 3'h0 && $past(q.ctrl[CTRL_PORT0_TIER_BIT]));
    endproperty
    a_bridge_tier: assert property (p_bridge_tier) else $error("bridge tier ignored");

    property p_port0_tier;
        @(posedge clk_in) disable iff (rst_in || hot_rst_in)
        (arb_go && q.hi_last == LOWER_SLOT && r_arb[0] && q.ctrl[CTRL_PORT0_TIER_BIT])
            |=> q.grantee == 3'h0;
    endproperty
    a_port0_tier: assert property (p_port0_tier) else $error("port 0 tier ignored");

    property p_auto_mask;
        @(posedge clk_in) disable iff (rst_in)
        (watch_bus.expired && q.grantee < BRIDGE_IDX && q.mask[MASK_AUTO_BIT])
            |=> q.amask[$past(q.grantee)];
    endproperty
    a_auto_mask: assert property (p_auto_mask) else $error("no auto mask");

    property p_ignore0;
        @(posedge clk_in) disable iff (rst_in || hot_rst_in)
        (arb_go && q.mask[MASK_IGNORE0_BIT] && r_arb != 7'h00) |=> q.grantee != 3'h0;
    endproperty
    a_ignore0: assert property (p_ignore0) else $error("request 0 granted");

    property p_flag_set;
        @(posedge clk_in) disable iff (rst_in)
        (watch_bus.expired && q.grantee < BRIDGE_IDX) |=> q.tstat[$past(q.grantee)];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("expiry flag missing");

    property p_flag_sticky;
        @(posedge clk_in) disable iff (rst_in)
        !clr_hit |=> (q.tstat & $past(q.tstat)) == $past(q.tstat);
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

    property p_rsvd_zero;
        @(posedge clk_in) disable iff (rst_in)
        (cfg_rd_in && cfg_addr_in == ADDR_TSTAT) |=> cfg_rdata_out[7:6] == 2'b00;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set");

    property p_hot_keeps;
        @(posedge clk_in) disable iff (rst_in)
        (hot_rst_in && !cfg_wr_in) |=> q.ctrl == $past(q.ctrl) && q.mask == $past(q.mask);
    endproperty
    a_hot_keeps: assert property (p_hot_keeps) else $error("hot reset hit config");
endmodule : sbarb_arbiter

/* verification/sbarb_master_model.sv */
`timescale 1ns/100ps
// ==========================================================
// Secondary bus masters seen from the arbiter
module sbarb_master_model (
    input wire logic clk_in,
    input wire logic [5:0] want_in,
    input wire logic [5:0] mute_in,
    input wire logic [5:0] grant_line_n_in,
    output logic [5:0] request_line_n_out,
    output logic frame_n_out,
    output logic irdy_n_out
);
    logic [2:0] len_ff = 3'h0;
    logic [5:0] start_ok;
    assign request_line_n_out = ~want_in;
    assign start_ok = ~grant_line_n_in & want_in & ~mute_in;
    // Granted master opens a short frame on the idle bus; muted ones never do
    always_ff @(posedge clk_in) begin
        if (len_ff != 3'h0) begin
            len_ff <= len_ff - 3'h1;
        end else if (start_ok != 6'h00) begin
            len_ff <= 3'h6;
        end
    end
    // Released lines return to their pulled-up idle level
    assign frame_n_out = !(len_ff > 3'h4);
    assign irdy_n_out = !(len_ff > 3'h2);
endmodule : sbarb_master_model

/* verification/secondary_bus_arbiter_bench.sv */
`timescale 1ns/100ps
module secondary_bus_arbiter_bench;
    import sbarb_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic hot_rst_in = 1'b0;
    logic bridge_req = 1'b0;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [5:0] want = 6'h00;
    logic [5:0] mute = 6'h00;
    logic [5:0] req_n;
    logic frame_n;
    logic irdy_n;
    logic [5:0] gnt_n;
    logic bridge_gnt;
    logic [7:0] rdata;
    int errors = 0;
    int checks_done = 0;
    always #12.5 clk_in = ~clk_in;
    // ==========================================================
    // Design and masters
    sbarb_arbiter dut_u (.clk_in(clk_in), .rst_in(rst_in), .hot_rst_in(hot_rst_in),
        .request_line_n_in(req_n), .frame_n_in(frame_n), .irdy_n_in(irdy_n),
        .bridge_req_in(bridge_req), .cfg_addr_in(addr), .cfg_wr_in(wr), .cfg_rd_in(rd),
        .cfg_wdata_in(wdata), .grant_line_n_out(gnt_n), .bridge_gnt_out(bridge_gnt),
        .cfg_rdata_out(rdata));
    sbarb_master_model master_u (.clk_in(clk_in), .want_in(want), .mute_in(mute),
        .grant_line_n_in(gnt_n), .request_line_n_out(req_n), .frame_n_out(frame_n),
        .irdy_n_out(irdy_n));
    // ==========================================================
    // Tasks
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk_in);
        wr = 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_in);
        addr = a;
        rd = 1'b1;
        @(negedge clk_in);
        rd = 1'b0;
        check("read data", rdata, exp);
    endtask : rd_reg
    task automatic hold_grant(input int n, input logic [7:0] exp);
        repeat (n) @(negedge clk_in);
        check("grant", {1'b0, bridge_gnt, gnt_n}, exp);
    endtask : hold_grant
    task automatic wait_grant(input logic [7:0] exp);
        for (int i = 0; i < 60 && {1'b0, bridge_gnt, gnt_n} !== exp; i++) begin
            @(negedge clk_in);
        end
        check("grant", {1'b0, bridge_gnt, gnt_n}, exp);
    endtask : wait_grant
    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize
    // ==========================================================
    // Tests
    initial begin
        repeat (2) @(negedge clk_in);
        rst_in = 1'b0;
        hold_grant(0, 8'h7f);
        rd_reg(ADDR_CTRL, 8'h40);
        rd_reg(ADDR_MASK, 8'h00);
        rd_reg(ADDR_TSTAT, 8'h00);
        rd_reg(8'hd8, 8'h00);
        want = 6'h08;
        wait_grant(8'h37);
        repeat (8) @(negedge clk_in);
        want = 6'h00;
        hold_grant(12, 8'h37);
        bridge_req = 1'b1;
        wait_grant(8'h7f);
        bridge_req = 1'b0;
        wr_reg(ADDR_CTRL, 8'hc0);
        wait_grant(8'h7f);
        wr_reg(ADDR_MASK, 8'h01);
        want = 6'h01;
        hold_grant(10, 8'h7f);
        wr_reg(ADDR_MASK, 8'h00);
        wait_grant(8'h3e);
        want = 6'h00;
        wait_grant(8'h7f);
        wr_reg(ADDR_MASK, 8'hc0);
        mute = 6'h04;
        want = 6'h04;
        wait_grant(8'h3b);
        hold_grant(14, 8'h3b);
        wait_grant(8'h7f);
        rd_reg(ADDR_TSTAT, 8'h04);
        hold_grant(20, 8'h7f);
        mute = 6'h00;
        wr_reg(ADDR_TSTAT, 8'h04);
        rd_reg(ADDR_TSTAT, 8'h00);
        wait_grant(8'h3b);
        want = 6'h00;
        @(negedge clk_in);
        hot_rst_in = 1'b1;
        @(negedge clk_in);
        hot_rst_in = 1'b0;
        hold_grant(0, 8'h7f);
        rd_reg(ADDR_CTRL, 8'hc0);
        rd_reg(ADDR_MASK, 8'hc0);
        // Port 0 raised to the high tier, bridge lowered
        wr_reg(ADDR_CTRL, 8'h81);
        want = 6'h02;
        wait_grant(8'h3d);
        want = 6'h09;
        wait_grant(8'h3e);
        want = 6'h00;
        wait_grant(8'h7f);
        summarize();
    end
    // Watchdog at 4000 cycles, well beyond the fewer than 200 cycles the tests need
    initial begin
        #100000;
        errors++;
        summarize();
    end
endmodule : secondary_bus_arbiter_bench
